// File: rtl/lce_irq.sv
// Implementation choices: the address map and the APB slave port.
`timescale 1ns/1ps
// Notes on behaviour
// - Drive alarm changes interrupt when bit 6 set
// - FIFO pointers within three bits interrupt, bit 5
// - Loop-code detect start and stop interrupt, bit 3
// - Signal loss declare and clear interrupt, bit 1
// - Test pattern detect start and stop, bit 0
// - Bits 7,4,2 unused; read zero, writes ignored
// - Interrupts work only in single-rail mode
// - Drive alarm after 128 silent bits; pulse clears
module lce_irq #(
   parameter int SILENT_BITS = lce_pkg::LCE_DRV_MON_BITS,
   parameter int PTR_W = 5
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire lce_pkg::lce_pins_t line_pins,
   input wire logic bit_tick,
   input wire logic [PTR_W-1:0] ja_wr_ptr,
   input wire logic [PTR_W-1:0] ja_rd_ptr,
   output logic irq
);
   import lce_pkg::*;

   // Width of the silent-bit counter
   localparam int CNT_W = $clog2(SILENT_BITS + 1);

   // Parameters the logic cannot serve are refused at elaboration
   generate
      if (SILENT_BITS < 2 || PTR_W < 3)
      begin : g_bad_param
         $error("lce_irq: SILENT_BITS or PTR_W out of range");
      end
   endgenerate

   // Enable register
   lce_evt_t irq_en_q;
   // Sticky source register
   lce_evt_t source_q;
   lce_evt_t source_d;
   // Single-rail controls for the line interface and framer
   logic [1:0] ctrl_q;
   // Previous filtered status, for change detection
   lce_evt_t status_prev_q;
   // Live status
   lce_evt_t status_now;
   // Drive alarm and silent-bit counter
   logic drv_mon_q;
   logic [CNT_W-1:0] silent_q;
   logic [CNT_W-1:0] silent_d;
   // Bus answer registers
   logic pready_q;
   logic [31:0] prdata_q;
   logic pslverr_q;
   // Interrupt output register
   logic irq_q;
   // Synchronised pins
   lce_pins_t pins_s;

   // Pins pass the three-stage synchroniser
   lce_sync #(
      .WIDTH(4)
   ) u_sync (
      .pclk(pclk),
      .presetn(presetn),
      .pin_in(line_pins),
      .sync_out(pins_s)
   );

   // Bus decode
   wire access = psel & penable;
   wire wr_commit = access & pready_q & pwrite;
   wire hit_en = (paddr == LCE_OFS_IRQ_EN);
   wire hit_st = (paddr == LCE_OFS_STATUS);
   wire hit_src = (paddr == LCE_OFS_SOURCE);
   wire hit_ctl = (paddr == LCE_OFS_CTRL);
   wire hit_any = hit_en | hit_st | hit_src | hit_ctl;
   wire wr_en = wr_commit & hit_en;
   wire wr_src = wr_commit & hit_src;
   wire wr_ctl = wr_commit & hit_ctl;

   // Both parties must be in single-rail mode
   wire rail_ok = ctrl_q[LCE_BIT_LIU_SR] & ctrl_q[LCE_BIT_FRM_SR];

   // Signed pointer distance of the jitter FIFO
   wire [PTR_W-1:0] ptr_diff = ja_wr_ptr - ja_rd_ptr;
   wire [PTR_W-1:0] ptr_ndiff = ja_rd_ptr - ja_wr_ptr;
   wire fifo_near = (ptr_diff <= PTR_W'(LCE_FIFO_LIMIT))
      | (ptr_ndiff <= PTR_W'(LCE_FIFO_LIMIT));

   // Live status, unused bits held at zero
   always_comb
   begin
      status_now = '0;
      status_now.drv_mon = drv_mon_q;
      status_now.fls = fifo_near;
      status_now.nlc = pins_s.loop_code;
      status_now.sig_loss = pins_s.rx_loss;
      status_now.qrp = pins_s.test_pattern;
   end

   // Change events per bit
   wire lce_evt_t toggled = status_now ^ status_prev_q;
   lce_evt_t evt_set;
   always_comb
   begin
      evt_set = '0;
      evt_set.drv_mon = toggled.drv_mon;
      evt_set.fls = status_now.fls & ~status_prev_q.fls;
      evt_set.nlc = toggled.nlc;
      evt_set.sig_loss = toggled.sig_loss;
      evt_set.qrp = toggled.qrp;
   end

   // Events record only when enabled and in single-rail mode
   wire lce_evt_t gated_set = rail_ok ? (evt_set & irq_en_q) : '0;
   wire lce_evt_t src_clr = wr_src ? lce_evt_t'(pwdata[7:0]) : '0;

   // Set wins over a write-one clear in the same cycle
   assign source_d = (source_q & ~src_clr) | gated_set;

   // Drive alarm counter: reset by any pulse, counts bit ticks
   always_comb
   begin
      silent_d = silent_q;
      if (pins_s.tx_pulse)
      begin
         silent_d = '0;
      end
      else if (bit_tick && silent_q != CNT_W'(SILENT_BITS))
      begin
         silent_d = silent_q + CNT_W'(1);
      end
   end

   // Drive monitor state
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         silent_q <= '0;
         drv_mon_q <= 1'b0;
      end
      else
      begin
         silent_q <= silent_d;
         drv_mon_q <= (silent_d == CNT_W'(SILENT_BITS));
      end
   end

   // Status history and sticky sources
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         status_prev_q <= '0;
         source_q <= LCE_RST_SOURCE;
      end
      else
      begin
         status_prev_q <= status_now;
         source_q <= source_d;
      end
   end

   // Writable registers
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         irq_en_q <= LCE_RST_IRQ_EN;
         ctrl_q <= LCE_RST_CTRL;
      end
      else
      begin
         if (wr_en)
         begin
            irq_en_q <= pwdata[7:0] & LCE_EN_WMASK;
         end
         if (wr_ctl)
         begin
            ctrl_q <= pwdata[1:0];
         end
      end
   end

   // Read mux
   wire [31:0] rd_val = hit_en ? {24'h000000, irq_en_q}
      : hit_st ? {24'h000000, status_now}
      : hit_src ? {24'h000000, source_q}
      : hit_ctl ? {30'h0, ctrl_q}
      : 32'h00000000;

   // One wait state: answer in the second access cycle
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         pready_q <= 1'b0;
         prdata_q <= 32'h00000000;
         pslverr_q <= 1'b0;
      end
      else
      begin
         pready_q <= access & ~pready_q;
         if (access && !pready_q)
         begin
            prdata_q <= pwrite ? 32'h00000000 : rd_val;
            pslverr_q <= ~hit_any;
         end
         else
         begin
            pslverr_q <= 1'b0;
         end
      end
   end

   // Single channel request from enabled pending sources
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         irq_q <= 1'b0;
      end
      else
      begin
         irq_q <= rail_ok & (|(source_d & irq_en_q));
      end
   end

   assign prdata = prdata_q;
   assign pready = pready_q;
   assign pslverr = pslverr_q;
   assign irq = irq_q;

   // Completed write to the source register
   sequence seq_src_write;
      psel && penable && pready && pwrite && paddr == LCE_OFS_SOURCE;
   endsequence

   // Any cycle that does not complete a source write
   sequence seq_quiet_bus;
      !(psel && penable && pready && pwrite && paddr == LCE_OFS_SOURCE);
   endsequence

   // Pending enabled event in single-rail mode
   sequence seq_pending;
      rail_ok && (source_q & irq_en_q) != 8'h00;
   endsequence

   // First access cycle of an enable register read
   sequence seq_en_read;
      psel && penable && !pready && !pwrite && paddr == LCE_OFS_IRQ_EN;
   endsequence

   // Last silent bit tick before the alarm count is full
   sequence seq_last_silent_tick;
      bit_tick && !pins_s.tx_pulse && silent_q == CNT_W'(SILENT_BITS - 1);
   endsequence

   // Drive alarm edges are recorded when enabled
   AST_DRV_MON_EVENT: assert property (@(posedge pclk) disable iff (!presetn)
      rail_ok && irq_en_q.drv_mon && $changed(drv_mon_q) |=> source_q.drv_mon)
      else $error("drive alarm change not recorded");

   // Entry into the pointer window is recorded when enabled
   AST_FLS_EVENT: assert property (@(posedge pclk) disable iff (!presetn)
      rail_ok && irq_en_q.fls && $rose(fifo_near) |=> source_q.fls)
      else $error("fifo limit not recorded");

   // Loop code start and stop are recorded when enabled
   AST_NLC_EVENT: assert property (@(posedge pclk) disable iff (!presetn)
      rail_ok && irq_en_q.nlc && $changed(pins_s.loop_code) |=> source_q.nlc)
      else $error("loop code change not recorded");

   // Signal loss declare and clear are recorded when enabled
   AST_SIG_LOSS_EVENT: assert property (@(posedge pclk) disable iff (!presetn)
      rail_ok && irq_en_q.sig_loss && $changed(pins_s.rx_loss) |=> source_q.sig_loss)
      else $error("signal loss change not recorded");

   // Test pattern start and stop are recorded when enabled
   AST_QRP_EVENT: assert property (@(posedge pclk) disable iff (!presetn)
      rail_ok && irq_en_q.qrp && $changed(pins_s.test_pattern)
      |=> source_q.qrp)
      else $error("test pattern change not recorded");

   // A source bit never rises while its enable is clear
   AST_EN_GATE: assert property (@(posedge pclk) disable iff (!presetn)
      ((source_q & ~$past(source_q)) & ~$past(irq_en_q)) == 8'h00)
      else $error("source set while disabled");

   // Unused enable bits stay clear
   AST_RSV_ZERO: assert property (@(posedge pclk) disable iff (!presetn)
      (irq_en_q & ~LCE_EN_WMASK) == 8'h00 && source_q.rsv7 == 1'b0)
      else $error("unused enable bit set");

   // Enable reads return zero in the unused bits
   AST_EN_READ: assert property (@(posedge pclk) disable iff (!presetn)
      seq_en_read |=> pready && (prdata[7:0] & ~LCE_EN_WMASK) == 8'h00)
      else $error("unused enable bit read as one");

   // No request outside single-rail mode
   AST_RAIL_BLOCK: assert property (@(posedge pclk) disable iff (!presetn)
      !rail_ok |=> !irq)
      else $error("interrupt outside single-rail mode");

   // No source bit rises outside single-rail mode
   AST_RAIL_GATE: assert property (@(posedge pclk) disable iff (!presetn)
      !$past(rail_ok) |-> (source_q & ~$past(source_q)) == 8'h00)
      else $error("source set outside single-rail mode");

   // A transmit pulse clears the alarm and the count
   AST_DRV_MON_CLEAR: assert property (@(posedge pclk) disable iff (!presetn)
      pins_s.tx_pulse |=> !drv_mon_q ##0 silent_q == '0)
      else $error("drive alarm not cleared by pulse");

   // The final silent tick declares the alarm
   AST_DRV_MON_SET: assert property (@(posedge pclk) disable iff (!presetn)
      seq_last_silent_tick |=> drv_mon_q)
      else $error("drive alarm not declared after silence");

   // The alarm stands only with a full count
   AST_DRV_MON_SILENT: assert property (@(posedge pclk) disable iff (!presetn)
      drv_mon_q |-> silent_q == CNT_W'(SILENT_BITS))
      else $error("drive alarm without full silence");

   // A pending enabled source holds the request
   AST_IRQ_HOLD: assert property (@(posedge pclk) disable iff (!presetn)
      seq_pending ##0 seq_quiet_bus |=> irq)
      else $error("pending source without request");

   // Writing all ones clears every source bit when nothing new is set
   AST_SRC_CLEAR: assert property (@(posedge pclk) disable iff (!presetn)
      seq_src_write ##0 pwdata[7:0] == 8'hFF ##0 gated_set == 8'h00 |=> source_q == 8'h00)
      else $error("source not cleared by write");
endmodule : lce_irq

// File: common/lce_pkg.sv
package lce_pkg;
   // Register byte offsets
   localparam logic [7:0] LCE_OFS_IRQ_EN = 8'h00;
   localparam logic [7:0] LCE_OFS_STATUS = 8'h04;
   localparam logic [7:0] LCE_OFS_SOURCE = 8'h08;
   localparam logic [7:0] LCE_OFS_CTRL = 8'h0C;
   // Bit positions of the channel event layout
   localparam int LCE_BIT_DRV_MON = 6;
   localparam int LCE_BIT_FLS = 5;
   localparam int LCE_BIT_NLC = 3;
   localparam int LCE_BIT_SIG_LOSS = 1;
   localparam int LCE_BIT_QRP = 0;
   // Writable bits of the enable register
   localparam logic [7:0] LCE_EN_WMASK = 8'h6B;
   // Control register fields
   localparam int LCE_BIT_LIU_SR = 0;
   localparam int LCE_BIT_FRM_SR = 1;
   // Values after reset
   localparam logic [7:0] LCE_RST_IRQ_EN = 8'h00;
   localparam logic [7:0] LCE_RST_SOURCE = 8'h00;
   localparam logic [1:0] LCE_RST_CTRL = 2'h0;
   // Bit periods without pulses before the drive alarm
   localparam int LCE_DRV_MON_BITS = 128;
   // Jitter FIFO pointer window, in bits
   localparam int LCE_FIFO_LIMIT = 3;
   // Channel event layout, shared by enable, status and source
   typedef struct packed
   {
      logic rsv7;
      logic drv_mon;
      logic fls;
      logic rsv4;
      logic nlc;
      logic rsv2;
      logic sig_loss;
      logic qrp;
   } lce_evt_t;
   // Line status inputs arriving from pins
   typedef struct packed
   {
      logic tx_pulse;
      logic loop_code;
      logic rx_loss;
      logic test_pattern;
   } lce_pins_t;
endpackage : lce_pkg

// File: rtl/lce_sync.sv
`timescale 1ns/1ps
// Three-stage pin synchroniser; output follows once stages two and three agree
module lce_sync #(
   parameter int WIDTH = 4
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic [WIDTH-1:0] pin_in,
   output logic [WIDTH-1:0] sync_out
);
   // Stage one, read only by stage two
   logic [WIDTH-1:0] meta_q;
   // Stages two and three
   logic [WIDTH-1:0] s2_q;
   logic [WIDTH-1:0] s3_q;
   // Filtered value
   logic [WIDTH-1:0] out_q;
   // Agreement of the two settled stages
   wire [WIDTH-1:0] agree = ~(s2_q ^ s3_q);

   // Shift chain and agreement filter
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         meta_q <= '0;
         s2_q <= '0;
         s3_q <= '0;
         out_q <= '0;
      end
      else
      begin
         meta_q <= pin_in;
         s2_q <= meta_q;
         s3_q <= s2_q;
         out_q <= (agree & s3_q) | (~agree & out_q);
      end
   end

   assign sync_out = out_q;
endmodule : lce_sync

// File: tb/lce_irq_tb.sv
`timescale 1ns/1ps
// APB bench for the channel interrupt enable block
module lce_irq_tb;
   import lce_pkg::*;
   // Bus side stimulus
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata;
   logic pready;
   logic pslverr;
   // Line side stimulus, transmit pulses present at start
   lce_pins_t pins = 4'h8;
   logic bit_tick = 1'b0;
   logic [4:0] wr_ptr = 5'h10;
   logic [4:0] rd_ptr = 5'h00;
   logic irq;
   // Last read data and error
   logic [31:0] rd;
   logic err;
   int mismatches = 0;
   int cmp_count = 0;
   // Pin index and event bit for loop code, signal loss, test pattern
   int pin_idx [3] = '{2, 1, 0};
   int src_idx [3] = '{3, 1, 0};

   // 50 ns clock
   always #25 pclk = ~pclk;

   // Short alarm count keeps the run brief
   lce_irq #(.SILENT_BITS(4), .PTR_W(5)) i_lce_irq (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .line_pins(pins), .bit_tick(bit_tick),
      .ja_wr_ptr(wr_ptr), .ja_rd_ptr(rd_ptr), .irq(irq));

   // Print counts and verdict, then stop
   task finish_test;
      $display("compares %0d mismatches %0d", cmp_count, mismatches);
      if (mismatches == 0 && cmp_count > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask : finish_test

   // Compare seen against expected
   task chk(input logic [31:0] seen, input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp)
      begin
         mismatches++;
         $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : chk

   // One APB transfer; the wait for pready is bounded
   task xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      do
      begin
         @(posedge pclk);
         n++;
      end
      while (pready !== 1'b1 && n < 16);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      if (pready !== 1'b1)
      begin
         mismatches++;
         finish_test();
      end
   endtask : xfer

   // Read a register and compare
   task rdchk(input logic [7:0] a, input logic [31:0] exp);
      xfer(1'b0, a, 32'h0);
      chk(rd, exp);
   endtask : rdchk

   // Idle cycles
   task cyc(input int n);
      repeat (n) @(posedge pclk);
   endtask : cyc

   // One bit period strobe
   task tick;
      @(posedge pclk);
      bit_tick <= 1'b1;
      @(posedge pclk);
      bit_tick <= 1'b0;
   endtask : tick

   // Main sequence
   initial
   begin
      cyc(4);
      presetn <= 1'b1;
      rdchk(LCE_OFS_IRQ_EN, 32'h0);
      rdchk(LCE_OFS_CTRL, 32'h0);
      rdchk(LCE_OFS_SOURCE, 32'h0);
      xfer(1'b1, LCE_OFS_IRQ_EN, 32'hFF);
      rdchk(LCE_OFS_IRQ_EN, 32'h6B);
      // Unmapped address is refused
      xfer(1'b0, 8'h10, 32'h0);
      chk({31'h0, err}, 32'h1);
      // Framer not single-rail: events ignored
      xfer(1'b1, LCE_OFS_CTRL, 32'h1);
      pins.rx_loss <= 1'b1;
      cyc(8);
      rdchk(LCE_OFS_SOURCE, 32'h0);
      chk({31'h0, irq}, 32'h0);
      pins.rx_loss <= 1'b0;
      cyc(8);
      xfer(1'b1, LCE_OFS_CTRL, 32'h3);
      // Disabled event stays silent
      xfer(1'b1, LCE_OFS_IRQ_EN, 32'h0);
      pins.loop_code <= 1'b1;
      cyc(8);
      rdchk(LCE_OFS_SOURCE, 32'h0);
      pins.loop_code <= 1'b0;
      cyc(8);
      xfer(1'b1, LCE_OFS_IRQ_EN, 32'hFF);
      // Both edges of each receive event interrupt
      for (int i = 0; i < 3; i++)
      begin
         pins[pin_idx[i]] <= 1'b1;
         cyc(8);
         rdchk(LCE_OFS_STATUS, 32'h1 << src_idx[i]);
         rdchk(LCE_OFS_SOURCE, 32'h1 << src_idx[i]);
         chk({31'h0, irq}, 32'h1);
         xfer(1'b1, LCE_OFS_SOURCE, 32'h1 << src_idx[i]);
         cyc(1);
         chk({31'h0, irq}, 32'h0);
         pins[pin_idx[i]] <= 1'b0;
         cyc(8);
         rdchk(LCE_OFS_SOURCE, 32'h1 << src_idx[i]);
         xfer(1'b1, LCE_OFS_SOURCE, 32'hFF);
      end
      // Request holds while any source is pending
      pins.loop_code <= 1'b1;
      pins.rx_loss <= 1'b1;
      cyc(8);
      xfer(1'b1, LCE_OFS_SOURCE, 32'h2);
      cyc(1);
      chk({31'h0, irq}, 32'h1);
      xfer(1'b1, LCE_OFS_SOURCE, 32'h8);
      cyc(1);
      chk({31'h0, irq}, 32'h0);
      pins.loop_code <= 1'b0;
      pins.rx_loss <= 1'b0;
      cyc(8);
      xfer(1'b1, LCE_OFS_SOURCE, 32'hFF);
      // Drive alarm declared on the fourth silent tick
      pins.tx_pulse <= 1'b0;
      cyc(6);
      repeat (3) tick();
      cyc(2);
      rdchk(LCE_OFS_STATUS, 32'h0);
      tick();
      cyc(2);
      rdchk(LCE_OFS_STATUS, 32'h40);
      rdchk(LCE_OFS_SOURCE, 32'h40);
      xfer(1'b1, LCE_OFS_SOURCE, 32'h40);
      pins.tx_pulse <= 1'b1;
      cyc(8);
      rdchk(LCE_OFS_STATUS, 32'h0);
      rdchk(LCE_OFS_SOURCE, 32'h40);
      xfer(1'b1, LCE_OFS_SOURCE, 32'hFF);
      // Pointer window edges: 2 in, 4 out, 3 in
      rd_ptr <= 5'h0E;
      cyc(4);
      rdchk(LCE_OFS_STATUS, 32'h20);
      rdchk(LCE_OFS_SOURCE, 32'h20);
      xfer(1'b1, LCE_OFS_SOURCE, 32'hFF);
      rd_ptr <= 5'h14;
      cyc(4);
      rdchk(LCE_OFS_STATUS, 32'h0);
      rdchk(LCE_OFS_SOURCE, 32'h0);
      rd_ptr <= 5'h13;
      cyc(4);
      rdchk(LCE_OFS_SOURCE, 32'h20);
      finish_test();
   end
endmodule : lce_irq_tb
